/* hdl/uhp_top.sv */
`timescale 1ns/1ps
`include "uhp_regs.svh"

// Contract
// - Select lines pick the channel register
// - Pick 0 means channel B, 1 channel A
// - Transfers happen only with chip select low
// - Dual write bit stores into both channels
// - Eight-bit bus, driven only during reads
// - Bit 0 is LSB, sent first
// - Interrupt needs control bit 3, enable, pending
// - Sources: errors, data, THR empty, modem
// - Read strobe low puts register on bus
// - Sixteen-entry TX and RX FIFOs, error flags
// - Four RX trigger levels, TX fixed
// - Five to eight bits, even/odd/no parity
// - DMA ready outputs follow FIFO levels
// - Separate baud generator per channel
// - Write strobe low stores bus to register
// - Reset clears registers, idles serial lines
// - TX ready low while any slot free
module uhp_top
  import uhp_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire uhp_host_req_t HOST_REQ,
  output logic [7:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE,
  output logic [1:0] CHANNEL_IRQ_OUT,
  output logic [1:0] RX_DMA_READY_N,
  output logic [1:0] TX_DMA_READY_N,
  output logic [1:0] SER_TX,
  input wire logic [1:0] SER_RX,
  input wire uhp_modem_n_t [1:0] MODEM_N
);

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  // Data bits per character, five to eight
  function automatic logic [3:0] char_len(input logic [7:0] lcr);
    char_len = {2'b00, lcr[1:0]} + `UHP_WL_BASE;
  endfunction

  // Returns {frame length, frame bits}; bit 0 goes out first
  function automatic logic [15:0] build_frame(input logic [7:0] d,
                                              input logic [7:0] lcr);
    logic [11:0] f;
    logic [3:0] wl;
    logic p;
    f = 12'hFFF;
    wl = char_len(lcr);
    p = ~lcr[`UHP_LCR_EPS];
    f[0] = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (4'(k) < wl) begin
        f[k+1] = d[k];
        p = p ^ d[k];
      end
    end
    if (lcr[`UHP_LCR_PEN]) begin
      f[wl+4'h1] = p;
    end
    build_frame = {wl + 4'h2 + {3'h0, lcr[`UHP_LCR_PEN]}
                   + {3'h0, lcr[`UHP_LCR_STOP]}, f};
  endfunction

  // ****************************************************************
  // Host port
  // ****************************************************************
  uhp_host_req_t hq_s1_ff, hq_s2_ff;
  logic rd_prev_ff, wr_prev_ff, nxt_rd_prev, nxt_wr_prev;
  logic [7:0] dout_ff, nxt_dout;
  logic oe_ff, nxt_oe;
  logic rd_act, wr_act, rd_start, wr_start, tgt;
  logic [1:0] rd_hit, wr_hit, dual_bits;
  logic [7:0] rd_data [2];

  // Host pins come from another domain: two stages before any use
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      hq_s1_ff <= '1;
      hq_s2_ff <= '1;
    end else begin
      hq_s1_ff <= HOST_REQ;
      hq_s2_ff <= hq_s1_ff;
    end
  end

  always_comb begin
    rd_act = !hq_s2_ff.cs_n && !hq_s2_ff.rd_n;
    wr_act = !hq_s2_ff.cs_n && !hq_s2_ff.wr_n;
    rd_start = rd_act && !rd_prev_ff;
    wr_start = wr_act && !wr_prev_ff;
    tgt = !hq_s2_ff.channel_pick;
    rd_hit = 2'b00;
    wr_hit = 2'b00;
    rd_hit[tgt] = rd_start;
    if (dual_bits != 2'b00) begin
      wr_hit = {wr_start, wr_start};
    end else begin
      wr_hit[tgt] = wr_start;
    end
    nxt_rd_prev = rd_act;
    nxt_wr_prev = wr_act;
    nxt_dout = rd_start ? rd_data[tgt] : dout_ff;
    // Bus released as soon as the strobe or select goes away
    nxt_oe = rd_act && (oe_ff || rd_start);
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      rd_prev_ff <= 1'b0;
      wr_prev_ff <= 1'b0;
      dout_ff <= 8'h00;
      oe_ff <= 1'b0;
    end else begin
      rd_prev_ff <= nxt_rd_prev;
      wr_prev_ff <= nxt_wr_prev;
      dout_ff <= nxt_dout;
      oe_ff <= nxt_oe;
    end
  end

  assign HOST_DATA_OUT = dout_ff;
  assign HOST_DATA_OE = oe_ff;

  // ****************************************************************
  // Channels: index 0 is A, index 1 is B
  // ****************************************************************
  for (genvar g = 0; g < 2; g++) begin : g_chan
    uhp_chan_t ch_ff, nxt_ch;
    logic [4:0] sync1_ff, sync2_ff;
    logic [7:0] tx_rdata, isr, msr_now, wd;
    logic [4:0] tx_cnt, rx_cnt, trig;
    logic [3:0] wl, stop_idx, chg;
    logic [2:0] sel;
    uhp_rx_entry_t rx_head, rx_new;
    logic tx_push, tx_pop, rx_push, rx_pop, tx_clr, rx_clr;
    logic rx_avail, tx_full, line_in, tick, dlab, head_err, par;

    // Serial and modem inputs are asynchronous to REF_CLK
    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        sync1_ff <= `UHP_SYNC_RST;
        sync2_ff <= `UHP_SYNC_RST;
      end else begin
        sync1_ff <= {MODEM_N[g], SER_RX[g]};
        sync2_ff <= sync1_ff;
      end
    end

    uhp_fifo #(.W(8)) u_tx_fifo (
      .clk(REF_CLK), .srst(SRST), .clr(tx_clr), .push(tx_push),
      .wdata(hq_s2_ff.wdata), .pop(tx_pop), .rdata(tx_rdata),
      .count(tx_cnt)
    );

    uhp_fifo #(.W(11)) u_rx_fifo (
      .clk(REF_CLK), .srst(SRST), .clr(rx_clr), .push(rx_push),
      .wdata(rx_new), .pop(rx_pop), .rdata(rx_head), .count(rx_cnt)
    );

    always_comb begin
      nxt_ch = ch_ff;
      tx_push = 1'b0;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      rx_pop = 1'b0;
      tx_clr = 1'b0;
      rx_clr = 1'b0;
      rx_new = '0;
      tick = 1'b0;
      par = 1'b0;
      sel = hq_s2_ff.sel;
      wd = hq_s2_ff.wdata;
      dlab = ch_ff.lcr[`UHP_LCR_DLAB];
      case (ch_ff.rx_trig)
        2'd0: trig = `UHP_TRIG_0;
        2'd1: trig = `UHP_TRIG_1;
        2'd2: trig = `UHP_TRIG_2;
        default: trig = `UHP_TRIG_3;
      endcase
      rx_avail = ch_ff.fifo_en ? (rx_cnt >= trig) : (rx_cnt != 5'h00);
      tx_full = ch_ff.fifo_en ? (tx_cnt == `UHP_FIFO_DEPTH)
                              : (tx_cnt != 5'h00);
      line_in = ch_ff.mctl[`UHP_MCTL_LOOP] ? ch_ff.txd : sync2_ff[0];
      msr_now = {~sync2_ff[4:1], ch_ff.msr[3:0]};
      head_err = (rx_cnt != 5'h00) && (rx_head.pe || rx_head.fe
                                       || rx_head.bi);
      wl = char_len(ch_ff.lcr);
      stop_idx = wl + 4'h1 + {3'h0, ch_ff.lcr[`UHP_LCR_PEN]};
      // Fixed priority among the four sources
      if (ch_ff.irq_en[`UHP_IEN_RLS] && (ch_ff.oe || head_err)) begin
        isr = `UHP_ISR_RLS;
      end else if (ch_ff.irq_en[`UHP_IEN_RDA] && rx_avail) begin
        isr = `UHP_ISR_RDA;
      end else if (ch_ff.irq_en[`UHP_IEN_THRE] && ch_ff.thre) begin
        isr = `UHP_ISR_THRE;
      end else if (ch_ff.irq_en[`UHP_IEN_MSI] && ch_ff.msr[3:0] != 4'h0) begin
        isr = `UHP_ISR_MSI;
      end else begin
        isr = `UHP_ISR_NONE;
      end
      if (ch_ff.fifo_en) begin
        isr = isr | `UHP_ISR_FIFO;
      end
      case (sel)
        `UHP_OFS_DATA: rd_data[g] = dlab ? ch_ff.dll : rx_head.data;
        `UHP_OFS_IEN: rd_data[g] = dlab ? ch_ff.dlm : {4'h0, ch_ff.irq_en};
        `UHP_OFS_ISR: rd_data[g] = dlab ? {7'h00, ch_ff.dual} : isr;
        `UHP_OFS_LCR: rd_data[g] = ch_ff.lcr;
        `UHP_OFS_MCTL: rd_data[g] = {3'h0, ch_ff.mctl};
        `UHP_OFS_LSR: rd_data[g] = {head_err,
          (tx_cnt == 5'h00) && (ch_ff.tx_st == UHP_IDLE),
          tx_cnt == 5'h00, rx_head.bi && rx_cnt != 5'h00,
          rx_head.fe && rx_cnt != 5'h00, rx_head.pe && rx_cnt != 5'h00,
          ch_ff.oe, rx_cnt != 5'h00};
        `UHP_OFS_MSR: rd_data[g] = msr_now;
        default: rd_data[g] = ch_ff.spr;
      endcase

      // Host write
      if (wr_hit[g]) begin
        case (sel)
          `UHP_OFS_DATA: begin
            if (dlab) begin
              nxt_ch.dll = wd;
            end else begin
              tx_push = !tx_full;
              nxt_ch.thre = 1'b0;
            end
          end
          `UHP_OFS_IEN: begin
            if (dlab) begin
              nxt_ch.dlm = wd;
            end else begin
              nxt_ch.irq_en = wd[3:0];
            end
          end
          `UHP_OFS_ISR: begin
            if (dlab) begin
              nxt_ch.dual = wd[`UHP_AFR_DUAL];
            end else begin
              // Switching FIFO mode flushes both FIFOs
              rx_clr = wd[`UHP_FCR_RXRST] || wd[0] != ch_ff.fifo_en;
              tx_clr = wd[`UHP_FCR_TXRST] || wd[0] != ch_ff.fifo_en;
              nxt_ch.fifo_en = wd[`UHP_FCR_EN];
              nxt_ch.dma_mode = wd[`UHP_FCR_DMA];
              nxt_ch.rx_trig = wd[7:6];
            end
          end
          `UHP_OFS_LCR: nxt_ch.lcr = wd;
          `UHP_OFS_MCTL: nxt_ch.mctl = wd[4:0];
          `UHP_OFS_SPR: nxt_ch.spr = wd;
          default: nxt_ch.spr = ch_ff.spr;
        endcase
      end

      // Read side effects, once per strobe
      if (rd_hit[g]) begin
        case (sel)
          `UHP_OFS_DATA: rx_pop = !dlab;
          `UHP_OFS_ISR: begin
            if (!dlab && isr[3:0] == 4'(`UHP_ISR_THRE)) begin
              nxt_ch.thre = 1'b0;
            end
          end
          `UHP_OFS_LSR: nxt_ch.oe = 1'b0;
          `UHP_OFS_MSR: nxt_ch.msr[3:0] = 4'h0;
          default: nxt_ch.oe = nxt_ch.oe;
        endcase
      end

      // Modem deltas; set after the read clear so events win
      chg = ~sync2_ff[4:1] ^ ch_ff.msr[7:4];
      nxt_ch.msr[7:4] = ~sync2_ff[4:1];
      nxt_ch.msr[3:0] = nxt_ch.msr[3:0] | {chg[3],
        ch_ff.msr[6] & sync2_ff[3], chg[1], chg[0]};

      // Baud generator at 16x; a zero divisor halts the channel
      if ({ch_ff.dlm, ch_ff.dll} != 16'h0000) begin
        if (ch_ff.baud_cnt == 16'h0000) begin
          nxt_ch.baud_cnt = {ch_ff.dlm, ch_ff.dll} - 16'h0001;
          tick = 1'b1;
        end else begin
          nxt_ch.baud_cnt = ch_ff.baud_cnt - 16'h0001;
        end
      end

      // Transmitter
      case (ch_ff.tx_st)
        UHP_IDLE: begin
          if (tx_cnt != 5'h00 && !tx_clr) begin
            tx_pop = 1'b1;
            {nxt_ch.tx_left, nxt_ch.tx_sh} =
              build_frame(tx_rdata, ch_ff.lcr);
            nxt_ch.tx_sub = 4'h0;
            nxt_ch.tx_st = UHP_BUSY;
            nxt_ch.thre = nxt_ch.thre || (tx_cnt == 5'h01 && !tx_push);
          end
        end
        UHP_BUSY: begin
          if (tick) begin
            nxt_ch.tx_sub = ch_ff.tx_sub + 4'h1;
            if (ch_ff.tx_sub == `UHP_SUB_LAST) begin
              nxt_ch.tx_sh = {1'b1, ch_ff.tx_sh[11:1]};
              nxt_ch.tx_left = ch_ff.tx_left - 4'h1;
              if (ch_ff.tx_left == 4'h1) begin
                nxt_ch.tx_st = UHP_IDLE;
              end
            end
          end
        end
        default: nxt_ch.tx_st = UHP_IDLE;
      endcase
      nxt_ch.txd = (nxt_ch.tx_st == UHP_BUSY) ? nxt_ch.tx_sh[0] : 1'b1;

      // Receiver: one stop bit is checked, sampled mid-bit
      for (int k = 0; k < 8; k++) begin
        if (4'(k) < wl) begin
          rx_new.data[k] = ch_ff.rx_sh[k+1];
          par = par ^ ch_ff.rx_sh[k+1];
        end
      end
      rx_new.pe = ch_ff.lcr[`UHP_LCR_PEN] && (par ^ ~ch_ff.lcr[`UHP_LCR_EPS]
                  ^ ch_ff.rx_sh[wl+4'h1]) != 1'b0;
      rx_new.fe = !line_in;
      rx_new.bi = !line_in && ch_ff.rx_sh == 12'h000;
      case (ch_ff.rx_st)
        UHP_IDLE: begin
          if (tick && !line_in) begin
            nxt_ch.rx_st = UHP_BUSY;
            nxt_ch.rx_sub = 4'h0;
            nxt_ch.rx_bitn = 4'h0;
            nxt_ch.rx_sh = 12'h000;
          end
        end
        UHP_BUSY: begin
          if (tick) begin
            nxt_ch.rx_sub = ch_ff.rx_sub + 4'h1;
            if (ch_ff.rx_sub == `UHP_SUB_MID) begin
              nxt_ch.rx_bitn = ch_ff.rx_bitn + 4'h1;
              nxt_ch.rx_sh[ch_ff.rx_bitn] = line_in;
              if (ch_ff.rx_bitn == 4'h0 && line_in) begin
                nxt_ch.rx_st = UHP_IDLE;
              end else if (ch_ff.rx_bitn == stop_idx) begin
                nxt_ch.rx_st = UHP_IDLE;
                if (ch_ff.fifo_en ? rx_cnt == `UHP_FIFO_DEPTH
                                  : rx_cnt != 5'h00) begin
                  nxt_ch.oe = 1'b1;
                end else begin
                  rx_push = 1'b1;
                end
              end
            end
          end
        end
        default: nxt_ch.rx_st = UHP_IDLE;
      endcase

      // Pin outputs
      nxt_ch.irq = ch_ff.mctl[`UHP_MCTL_IRQ_EN] && !isr[0];
      nxt_ch.rx_rdy_n = !((ch_ff.fifo_en && ch_ff.dma_mode) ? rx_avail
                          : rx_cnt != 5'h00);
      nxt_ch.tx_rdy_n = tx_full;
    end

    always_ff @(posedge REF_CLK) begin
      if (SRST) begin
        ch_ff <= '0;
        ch_ff.lcr <= `UHP_LCR_RST;
        ch_ff.mctl <= `UHP_MCTL_RST;
        ch_ff.irq_en <= `UHP_IEN_RST;
        ch_ff.dll <= `UHP_DIV_RST;
        ch_ff.dlm <= `UHP_DIV_RST;
        ch_ff.tx_st <= UHP_IDLE;
        ch_ff.rx_st <= UHP_IDLE;
        ch_ff.txd <= 1'b1;
        ch_ff.rx_rdy_n <= 1'b1;
        ch_ff.tx_rdy_n <= `UHP_TX_RDY_RST;
      end else begin
        ch_ff <= nxt_ch;
      end
    end

    assign dual_bits[g] = ch_ff.dual;
    assign CHANNEL_IRQ_OUT[g] = ch_ff.irq;
    assign RX_DMA_READY_N[g] = ch_ff.rx_rdy_n;
    assign TX_DMA_READY_N[g] = ch_ff.tx_rdy_n;
    assign SER_TX[g] = ch_ff.txd;
  end

endmodule

/* common/uhp_regs.svh */
`ifndef UHP_REGS_SVH
`define UHP_REGS_SVH

// ****************************************************************
// Register offsets within one channel
// ****************************************************************
`define UHP_OFS_DATA 3'h0
`define UHP_OFS_IEN 3'h1
`define UHP_OFS_ISR 3'h2
`define UHP_OFS_LCR 3'h3
`define UHP_OFS_MCTL 3'h4
`define UHP_OFS_LSR 3'h5
`define UHP_OFS_MSR 3'h6
`define UHP_OFS_SPR 3'h7

// ****************************************************************
// Field positions
// ****************************************************************
`define UHP_LCR_STOP 2
`define UHP_LCR_PEN 3
`define UHP_LCR_EPS 4
`define UHP_LCR_DLAB 7
`define UHP_MCTL_IRQ_EN 3
`define UHP_MCTL_LOOP 4
`define UHP_FCR_EN 0
`define UHP_FCR_RXRST 1
`define UHP_FCR_TXRST 2
`define UHP_FCR_DMA 3
`define UHP_AFR_DUAL 0
`define UHP_IEN_RDA 0
`define UHP_IEN_THRE 1
`define UHP_IEN_RLS 2
`define UHP_IEN_MSI 3

// ****************************************************************
// Interrupt identification codes
// ****************************************************************
`define UHP_ISR_NONE 8'h01
`define UHP_ISR_RLS 8'h06
`define UHP_ISR_RDA 8'h04
`define UHP_ISR_THRE 8'h02
`define UHP_ISR_MSI 8'h00
`define UHP_ISR_FIFO 8'hC0

// ****************************************************************
// Reset values
// ****************************************************************
`define UHP_LCR_RST 8'h00
`define UHP_MCTL_RST 5'h00
`define UHP_IEN_RST 4'h0
`define UHP_DIV_RST 8'h00
`define UHP_SYNC_RST 5'h1F
`define UHP_TX_RDY_RST 1'b0

// ****************************************************************
// FIFO and timing counts
// ****************************************************************
`define UHP_FIFO_DEPTH 5'h10
`define UHP_TRIG_0 5'h01
`define UHP_TRIG_1 5'h04
`define UHP_TRIG_2 5'h08
`define UHP_TRIG_3 5'h0E
`define UHP_SUB_LAST 4'hF
`define UHP_SUB_MID 4'h7
`define UHP_WL_BASE 4'h5

`endif

/* common/uhp_pkg.sv */
package uhp_pkg;

  typedef struct packed {
    logic cs_n;
    logic channel_pick;
    logic rd_n;
    logic wr_n;
    logic [2:0] sel;
    logic [7:0] wdata;
  } uhp_host_req_t;

  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } uhp_modem_n_t;

  typedef enum logic [1:0] {
    UHP_IDLE = 2'b01,
    UHP_BUSY = 2'b10
  } uhp_line_st_t;

  typedef struct packed {
    logic bi;
    logic fe;
    logic pe;
    logic [7:0] data;
  } uhp_rx_entry_t;

  typedef struct packed {
    logic [7:0] lcr;
    logic [3:0] irq_en;
    logic [4:0] mctl;
    logic [7:0] dll;
    logic [7:0] dlm;
    logic fifo_en;
    logic dma_mode;
    logic [1:0] rx_trig;
    logic [7:0] spr;
    logic dual;
    logic oe;
    logic thre;
    logic [7:0] msr;
    logic [15:0] baud_cnt;
    uhp_line_st_t tx_st;
    logic [3:0] tx_sub;
    logic [3:0] tx_left;
    logic [11:0] tx_sh;
    uhp_line_st_t rx_st;
    logic [3:0] rx_sub;
    logic [3:0] rx_bitn;
    logic [11:0] rx_sh;
    logic txd;
    logic irq;
    logic rx_rdy_n;
    logic tx_rdy_n;
  } uhp_chan_t;

endpackage

/* hdl/uhp_fifo.sv */
`timescale 1ns/1ps
`include "uhp_regs.svh"

module uhp_fifo
  import uhp_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clr,
  input wire logic push,
  input wire logic [W-1:0] wdata,
  input wire logic pop,
  output logic [W-1:0] rdata,
  output logic [4:0] count
);

  logic [W-1:0] mem_ff [16];
  logic [3:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [4:0] cnt_ff, nxt_cnt;
  logic do_push, do_pop;

  // Push into a full FIFO is dropped; the RX caller flags the overrun, the TX caller drops the byte without a flag
  always_comb begin
    do_push = push && (cnt_ff != `UHP_FIFO_DEPTH);
    do_pop = pop && (cnt_ff != 5'h00);
    nxt_wp = wp_ff + {3'h0, do_push};
    nxt_rp = rp_ff + {3'h0, do_pop};
    nxt_cnt = cnt_ff + {4'h0, do_push} - {4'h0, do_pop};
    if (clr) begin
      nxt_wp = 4'h0;
      nxt_rp = 4'h0;
      nxt_cnt = 5'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wp_ff <= 4'h0;
      rp_ff <= 4'h0;
      cnt_ff <= 5'h00;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (do_push && !clr) begin
      mem_ff[wp_ff] <= wdata;
    end
  end

  assign rdata = mem_ff[rp_ff];
  assign count = cnt_ff;

endmodule

/* sim/uhp_host_model.sv */
`timescale 1ns/1ps
module uhp_host_model
  import uhp_pkg::*;
(
  input wire logic clk,
  output uhp_host_req_t req,
  input wire logic [7:0] dout,
  input wire logic oe
);
  // Undriven bus floats; a read that misses OE returns z
  wire logic [7:0] host_bus = oe ? dout : 8'hzz;

  initial begin
    req = 15'h7800;
  end

  task automatic acc(input logic wr, input logic ch, input logic [2:0] s,
                     input logic [7:0] d, input logic cs,
                     output logic [7:0] q);
    @(negedge clk);
    req.cs_n = cs;
    req.channel_pick = ch;
    req.sel = s;
    req.wdata = d;
    // Address settles three clocks ahead of the strobe
    repeat (3) @(negedge clk);
    if (wr) begin
      req.wr_n = 1'b0;
    end else begin
      req.rd_n = 1'b0;
    end
    repeat (5) @(posedge clk);
    q = host_bus;
    @(negedge clk);
    req.wr_n = 1'b1;
    req.rd_n = 1'b1;
    repeat (3) @(negedge clk);
    req.cs_n = 1'b1;
    req.sel = ~s;
    req.wdata = ~d;
  endtask
endmodule

/* sim/uhp_top_sva.sv */
`timescale 1ns/1ps
module uhp_top_sva
  import uhp_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire uhp_host_req_t HOST_REQ,
  input wire logic [7:0] HOST_DATA_OUT,
  input wire logic HOST_DATA_OE,
  input wire logic [1:0] CHANNEL_IRQ_OUT,
  input wire logic [1:0] RX_DMA_READY_N,
  input wire logic [1:0] TX_DMA_READY_N,
  input wire logic [1:0] SER_TX,
  input wire logic [1:0] SER_RX,
  input wire uhp_modem_n_t [1:0] MODEM_N
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);

  logic rd_on;
  logic wr_on;
  logic [3:0] since_wr_ff;
  logic any_wr_ff;
  assign rd_on = !HOST_REQ.cs_n && !HOST_REQ.rd_n;
  assign wr_on = !HOST_REQ.cs_n && !HOST_REQ.wr_n;

  // Age of the last write strobe, saturating so it never wraps
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      since_wr_ff <= 4'hF;
      any_wr_ff <= 1'b0;
    end else begin
      since_wr_ff <= wr_on ? 4'h0 : since_wr_ff + {3'h0, since_wr_ff != 4'hF};
      any_wr_ff <= any_wr_ff | wr_on;
    end
  end

  sequence rd_held;
    rd_on [*4];
  endsequence

  AST_RESET_OUTS: assert property (@(posedge REF_CLK) disable iff (1'b0)
    SRST |=> !HOST_DATA_OE && CHANNEL_IRQ_OUT == 2'b00 && SER_TX == 2'b11
    && RX_DMA_READY_N == 2'b11 && TX_DMA_READY_N == 2'b00)
    else $error("outputs not at reset values");
  AST_OE_CAUSE: assert property (HOST_DATA_OE |->
    $past(rd_on, 2) || $past(rd_on, 3) || $past(rd_on, 4))
    else $error("bus driven without a read strobe");
  AST_RD_HELD: assert property (rd_held |-> HOST_DATA_OE)
    else $error("read strobe held but bus not driven");
  AST_RD_RELEASE: assert property ($rose(HOST_REQ.rd_n) |->
    ##[1:4] !HOST_DATA_OE)
    else $error("bus still driven after read strobe release");
  AST_CS_QUIET: assert property (HOST_REQ.cs_n [*5] |-> !HOST_DATA_OE)
    else $error("bus driven while chip select high");
  AST_DATA_HOLD: assert property ($fell(HOST_DATA_OE) |=>
    $stable(HOST_DATA_OUT))
    else $error("read data changed after bus release");
  AST_TX_DMA_READY_N_RISE: assert property ($rose(TX_DMA_READY_N[0]) |->
    since_wr_ff < 4'h7)
    else $error("tx ready went high without a write");
  AST_SER_IDLE: assert property (!any_wr_ff |-> SER_TX == 2'b11)
    else $error("serial output left idle before any write");
endmodule

bind uhp_top uhp_top_sva u_uhp_top_sva (
  .REF_CLK, .SRST, .HOST_REQ, .HOST_DATA_OUT, .HOST_DATA_OE,
  .CHANNEL_IRQ_OUT, .RX_DMA_READY_N, .TX_DMA_READY_N, .SER_TX, .SER_RX,
  .MODEM_N
);

/* sim/test_dual_uart_host_bus_port.sv */
`timescale 1ns/1ps
module test_dual_uart_host_bus_port
  import uhp_pkg::*;
;
  logic clk;
  logic srst;
  uhp_host_req_t host_req;
  logic [7:0] dout;
  logic oe;
  logic [1:0] irq, rxr_n, txr_n, ser_tx;
  uhp_modem_n_t [1:0] modem_n;
  int n_fail, samples_checked, cyc;

  // Channel A transmits into channel B's receiver and back
  uhp_top u_uhp_top (
    .REF_CLK(clk), .SRST(srst), .HOST_REQ(host_req),
    .HOST_DATA_OUT(dout), .HOST_DATA_OE(oe), .CHANNEL_IRQ_OUT(irq),
    .RX_DMA_READY_N(rxr_n), .TX_DMA_READY_N(txr_n), .SER_TX(ser_tx),
    .SER_RX({ser_tx[0], ser_tx[1]}), .MODEM_N(modem_n)
  );
  uhp_host_model u_uhp_host_model (
    .clk(clk), .req(host_req), .dout(dout), .oe(oe)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      finish_test;
    end
  end

  task automatic finish_test;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: byte %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmpf(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t: bits %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic ch, input logic [2:0] s, input logic [7:0] d);
    logic [7:0] q;
    u_uhp_host_model.acc(1'b1, ch, s, d, 1'b0, q);
  endtask

  task automatic rd(input logic ch, input logic [2:0] s,
                    output logic [7:0] q);
    u_uhp_host_model.acc(1'b0, ch, s, 8'h00, 1'b0, q);
  endtask

  task automatic grab(input int nb, output logic [11:0] f);
    f = 12'hFFF;
    // Sample on the falling edge, away from the edge that moves the line
    for (int t = 0; t < 800 && ser_tx[0] !== 1'b0; t++) @(negedge clk);
    repeat (8) @(negedge clk);
    for (int i = 0; i < nb; i++) begin
      repeat (16) @(negedge clk);
      f[i] = ser_tx[0];
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [7:0] q;
    cmpf(12'(txr_n), 12'h000);
    cmpf(12'(rxr_n), 12'h003);
    cmpf(12'(irq), 12'h000);
    rd(1'b1, 3'h3, q);
    cmp8(q, 8'h00);
    rd(1'b0, 3'h4, q);
    cmp8(q, 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_route;
    logic [7:0] q;
    wr(1'b1, 3'h7, 8'h5A);
    wr(1'b0, 3'h7, 8'hA5);
    // Deselected write and read must leave no trace
    u_uhp_host_model.acc(1'b1, 1'b1, 3'h7, 8'hFF, 1'b1, q);
    u_uhp_host_model.acc(1'b0, 1'b1, 3'h7, 8'h00, 1'b1, q);
    cmp8(q, 8'hzz);
    rd(1'b1, 3'h7, q);
    cmp8(q, 8'h5A);
    rd(1'b0, 3'h7, q);
    cmp8(q, 8'hA5);
    rd(1'b1, 3'h3, q);
    cmp8(q, 8'h00);
    $display("t_route done");
  endtask

  task automatic t_dual;
    logic [7:0] q;
    wr(1'b1, 3'h3, 8'h80);
    wr(1'b1, 3'h2, 8'h01);
    wr(1'b1, 3'h3, 8'h00);
    wr(1'b0, 3'h7, 8'h3C);
    rd(1'b1, 3'h7, q);
    cmp8(q, 8'h3C);
    rd(1'b0, 3'h7, q);
    cmp8(q, 8'h3C);
    $display("t_dual done");
  endtask

  task automatic t_serial;
    logic [7:0] l, d, m, q;
    logic [11:0] e, f;
    logic [7:0] cfg [4];
    int wl;
    cfg = '{8'h00, 8'h0A, 8'h1A, 8'h1B};
    d = 8'hB4;
    wr(1'b1, 3'h3, 8'h80);
    wr(1'b1, 3'h0, 8'h01);
    wr(1'b1, 3'h1, 8'h00);
    for (int k = 0; k < 4; k++) begin
      l = cfg[k];
      wl = int'(l[1:0]) + 5;
      m = 8'hFF >> (8 - wl);
      e = 12'hFFF;
      for (int i = 0; i < wl; i++) e[i] = d[i];
      if (l[3]) e[wl] = l[4] ? ^(d & m) : ~^(d & m);
      wr(1'b1, 3'h3, l);
      fork
        wr(1'b1, 3'h0, d);
        grab(wl + int'(l[3]) + 1, f);
      join
      cmpf(f, e);
      repeat (16) @(negedge clk);
      cmpf(12'(rxr_n), 12'h000);
      rd(1'b0, 3'h0, q);
      cmp8(q, d & m);
      rd(1'b1, 3'h0, q);
      cmp8(q, d & m);
    end
    $display("t_serial done");
  endtask

  task automatic t_irq;
    logic [7:0] q;
    wr(1'b1, 3'h1, 8'h08);
    @(negedge clk);
    modem_n[0].cts_n = 1'b0;
    repeat (10) @(negedge clk);
    cmpf(12'(irq), 12'h000);
    wr(1'b1, 3'h4, 8'h08);
    cmpf(12'(irq), 12'h001);
    rd(1'b1, 3'h6, q);
    cmp8(q, 8'h11);
    cmpf(12'(irq), 12'h000);
    $display("t_irq done");
  endtask

  task automatic t_tx_dma_ready_n;
    // Divisor 0 halts the shifters so the FIFO can be filled
    wr(1'b1, 3'h3, 8'h80);
    wr(1'b1, 3'h0, 8'h00);
    wr(1'b1, 3'h3, 8'h03);
    wr(1'b1, 3'h2, 8'h01);
    cmpf(12'(rxr_n), 12'h003);
    // The first byte moves straight into the halted shifter
    for (int i = 0; i < 17; i++) begin
      cmpf(12'(txr_n), 12'h000);
      wr(1'b1, 3'h0, 8'(i));
    end
    cmpf(12'(txr_n), 12'h003);
    wr(1'b1, 3'h2, 8'h05);
    cmpf(12'(txr_n), 12'h000);
    $display("t_tx_dma_ready_n done");
  endtask

  initial begin
    srst = 1'b1;
    modem_n = '1;
    repeat (12) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    t_reset;
    t_route;
    t_dual;
    t_serial;
    t_irq;
    t_tx_dma_ready_n;
    finish_test;
  end
endmodule
